//--- src/dcap_cmd_port.sv
/*
 Command and address front end of an eight-bank DDR3 memory: command
 decode, per-bank open row tracking, read/write burst sequencing with
 column ordering, and clock-gate freeze with power-down entry.
 Assumes i_clk is the rising crossing of the differential clock pair;
 pin inputs are synchronised here, mode inputs come from local logic.
*/
`include "dcap_params.svh"
`default_nettype none
module dcap_cmd_port (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_cke,
   input wire dcap_pkg::dcap_pins_t i_pins,
   input wire logic [4:0] i_column_latency,
   input wire logic [1:0] i_additive_latency,
   input wire logic i_burst_len8,
   input wire logic i_burst_otf,
   input wire logic i_burst_interleave,
   output logic [`DCAP_BANKS-1:0] o_bank_open,
   output logic [`DCAP_BANKS-1:0][`DCAP_ROW_W-1:0] o_open_rows,
   output dcap_pkg::dcap_beat_t o_beat,
   output dcap_pkg::dcap_pwr_t o_pwr_state
);
   dcap_pkg::dcap_pins_t pin_m_q, pin_s_q;
   logic cke_m_q, cke_s_q, cke_prev_q;
   dcap_pkg::dcap_burst_t st_q;
   dcap_pkg::dcap_pwr_t pwr_q, pwr_d;
   logic [`DCAP_LAT_W-1:0] cnt_q, lat_q, hc_q;
   logic [1:0] k_q;
   logic [`DCAP_COL_W-1:0] col_q;
   logic [`DCAP_BANK_W-1:0] bank_q;
   logic [`DCAP_ROW_W-1:0] rrow_q;
   logic ap_q, wr_q, len8_q, il_q;
   logic [`DCAP_BANKS-1:0] open_q;
   logic [`DCAP_BANKS-1:0][`DCAP_ROW_W-1:0] rows_q;
   dcap_pkg::dcap_beat_t beat_q;

   // Pins cross from the board, so two stages precede any decode.
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         pin_m_q <= `DCAP_PINS_RST;
         pin_s_q <= `DCAP_PINS_RST;
         cke_m_q <= `DCAP_CKE_RST;
         cke_s_q <= `DCAP_CKE_RST;
         cke_prev_q <= `DCAP_CKE_RST;
      end else begin
         pin_m_q <= i_pins;
         pin_s_q <= pin_m_q;
         cke_m_q <= i_cke;
         cke_s_q <= cke_m_q;
         cke_prev_q <= cke_s_q;
      end
   end

   // Command decode; the internal clock runs while the last sample was high.
   logic run_w, cmd_ok_w, act_w, pre_w, rd_w, wr_w, col_w, entry_w, sref_w;
   assign run_w = cke_prev_q;
   assign cmd_ok_w = cke_prev_q & cke_s_q & ~pin_s_q.cs_n;
   assign act_w = cmd_ok_w & ~pin_s_q.ras_n & pin_s_q.cas_n & pin_s_q.we_n;
   assign pre_w = cmd_ok_w & ~pin_s_q.ras_n & pin_s_q.cas_n & ~pin_s_q.we_n;
   assign rd_w = cmd_ok_w & pin_s_q.ras_n & ~pin_s_q.cas_n & pin_s_q.we_n;
   assign wr_w = cmd_ok_w & pin_s_q.ras_n & ~pin_s_q.cas_n & ~pin_s_q.we_n;
   assign col_w = rd_w | wr_w;
   assign entry_w = cke_prev_q & ~cke_s_q;
   assign sref_w = entry_w & ~pin_s_q.cs_n & ~pin_s_q.ras_n & ~pin_s_q.cas_n
                   & pin_s_q.we_n;

   // Read latency is additive plus column latency.
   logic [4:0] addlat_w;
   logic [`DCAP_LAT_W-1:0] lat_w;
   logic len8_w, last_w, emit_w, close_w;
   assign addlat_w = (i_additive_latency == `DCAP_ADDLAT_LESS1) ? i_column_latency - 5'h1 :
                     (i_additive_latency == `DCAP_ADDLAT_LESS2) ? i_column_latency - 5'h2 :
                     5'h0;
   assign lat_w = {1'b0, i_column_latency} + {1'b0, addlat_w};
   assign len8_w = i_burst_otf ? pin_s_q.addr[`DCAP_BC_BIT] : i_burst_len8;
   assign last_w = (k_q == (len8_q ? `DCAP_LAST_BL8 : `DCAP_LAST_BL4));
   assign emit_w = run_w & ((st_q == dcap_pkg::DCAP_WAIT && cnt_q == 6'h1) ||
                            st_q == dcap_pkg::DCAP_BURST);
   assign close_w = emit_w & last_w & ap_q;

   // Column order within the eight-word block; the upper bits stay put.
   function automatic logic [`DCAP_COL_W-1:0] dcap_col(
      input logic [`DCAP_COL_W-1:0] s, input logic [2:0] i, input logic il);
      logic [2:0] lo;
      lo = il ? (s[2:0] ^ i) : {s[2] ^ i[2], s[1:0] + i[1:0]};
      return {s[`DCAP_COL_W-1:3], lo};
   endfunction

   // Burst sequencer; a new column command restarts it.
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         st_q <= dcap_pkg::DCAP_IDLE;
         cnt_q <= 6'h0;
         k_q <= 2'h0;
      end else if (col_w) begin
         st_q <= dcap_pkg::DCAP_WAIT;
         cnt_q <= lat_w;
         k_q <= 2'h0;
      end else if (run_w) begin
         case (st_q)
            dcap_pkg::DCAP_WAIT: begin
               if (cnt_q == 6'h1) begin
                  st_q <= dcap_pkg::DCAP_BURST;
                  k_q <= 2'h1;
               end else begin
                  cnt_q <= cnt_q - 6'h1;
               end
            end
            dcap_pkg::DCAP_BURST: begin
               if (last_w) begin
                  st_q <= dcap_pkg::DCAP_IDLE;
                  k_q <= 2'h0;
               end else begin
                  k_q <= k_q + 2'h1;
               end
            end
            default: st_q <= dcap_pkg::DCAP_IDLE;
         endcase
      end
   end

   // Column command capture, held for the whole burst.
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         col_q <= 10'h0;
         bank_q <= 3'h0;
         rrow_q <= 13'h0;
         ap_q <= 1'b0;
         wr_q <= 1'b0;
         len8_q <= 1'b0;
         il_q <= 1'b0;
         lat_q <= 6'h0;
      end else if (col_w) begin
         col_q <= pin_s_q.addr[`DCAP_COL_W-1:0];
         bank_q <= pin_s_q.bank;
         rrow_q <= rows_q[pin_s_q.bank];
         ap_q <= pin_s_q.addr[`DCAP_AP_BIT];
         wr_q <= wr_w;
         len8_q <= len8_w;
         il_q <= i_burst_interleave;
         lat_q <= lat_w;
      end
   end

   // Each clock carries the rising-edge beat and the falling-edge beat.
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         beat_q <= '0;
      end else if (run_w) begin
         beat_q.valid <= emit_w;
         if (emit_w) begin
            beat_q.write <= wr_q;
            beat_q.bank <= bank_q;
            beat_q.row <= rrow_q;
            beat_q.col_rise <= dcap_col(col_q, {k_q, 1'b0}, il_q);
            beat_q.col_fall <= dcap_col(col_q, {k_q, 1'b1}, il_q);
         end
      end
   end

   // Per-bank row state; banks are independent of each other.
   for (genvar g = 0; g < `DCAP_BANKS; g++) begin : g_bank
      logic hit_w, shut_w;
      assign hit_w = (pin_s_q.bank == 3'(g));
      assign shut_w = (pre_w && (pin_s_q.addr[`DCAP_AP_BIT] || hit_w)) ||
                      (close_w && bank_q == 3'(g));
      always_ff @(posedge i_clk) begin
         if (!i_resetn) begin
            open_q[g] <= 1'b0;
            rows_q[g] <= 13'h0;
         end else if (act_w && hit_w) begin
            open_q[g] <= 1'b1;
            rows_q[g] <= pin_s_q.addr;
         end else if (shut_w) begin
            open_q[g] <= 1'b0;
         end
      end
   end

   // Power state; open rows at entry give active power-down.
   always_comb begin
      pwr_d = pwr_q;
      if (pwr_q == dcap_pkg::DCAP_RUN) begin
         if (entry_w) begin
            pwr_d = sref_w ? dcap_pkg::DCAP_SREF :
                    (|open_q) ? dcap_pkg::DCAP_PD_ACT : dcap_pkg::DCAP_PD_PRE;
         end
      end else if (cke_s_q) begin
         pwr_d = dcap_pkg::DCAP_RUN;
      end
   end

   // Power register; every low-power state leaves on the first high gate sample.
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         pwr_q <= dcap_pkg::DCAP_RUN;
      end else begin
         pwr_q <= pwr_d;
      end
   end

   // Every output is a register, so the far side never sees decode glitches.
   assign o_bank_open = open_q;
   assign o_open_rows = rows_q;
   assign o_beat = beat_q;
   assign o_pwr_state = pwr_q;

   // Helper: running clocks since the last column command.
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         hc_q <= 6'h0;
      end else if (col_w) begin
         hc_q <= 6'h1;
      end else if (run_w && hc_q != 6'h3f) begin
         hc_q <= hc_q + 6'h1;
      end
   end

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);

   // Entry is the first low gate sample while running; wake is the first high one.
   sequence s_entry_idle;
      pwr_q == dcap_pkg::DCAP_RUN && entry_w && !sref_w && open_q == 8'h0;
   endsequence
   sequence s_entry_open;
      pwr_q == dcap_pkg::DCAP_RUN && entry_w && !sref_w && open_q != 8'h0;
   endsequence
   sequence s_entry_sref;
      pwr_q == dcap_pkg::DCAP_RUN && entry_w && sref_w;
   endsequence
   sequence s_wake;
      pwr_q != dcap_pkg::DCAP_RUN && cke_s_q;
   endsequence

   AST_CS_MASK: assert property (
      (pin_s_q.cs_n && st_q != dcap_pkg::DCAP_BURST && st_q != dcap_pkg::DCAP_WAIT)
      |=> $stable(o_bank_open) && $stable(o_open_rows))
      else $error("Masked command changed bank state.");
   AST_ACT_ROW: assert property (
      act_w |=> o_bank_open[$past(pin_s_q.bank)] &&
                o_open_rows[$past(pin_s_q.bank)] == $past(pin_s_q.addr))
      else $error("Activate did not open the addressed row.");
   AST_PRE_ALL: assert property (
      pre_w && pin_s_q.addr[`DCAP_AP_BIT] |=> o_bank_open == 8'h0)
      else $error("Precharge all left a bank open.");
   AST_PRE_ONE: assert property (
      pre_w && !pin_s_q.addr[`DCAP_AP_BIT] |=> !o_bank_open[$past(pin_s_q.bank)])
      else $error("Precharge left the addressed bank open.");
   AST_FREEZE: assert property (
      !cke_prev_q |=> $stable(o_beat) && $stable(st_q) && $stable(k_q))
      else $error("State moved while the clock was gated.");
   AST_PD_PRE: assert property (
      s_entry_idle |=> o_pwr_state == dcap_pkg::DCAP_PD_PRE)
      else $error("Idle entry did not give precharge power-down.");
   AST_PD_ACT: assert property (
      s_entry_open |=> o_pwr_state == dcap_pkg::DCAP_PD_ACT)
      else $error("Entry with open rows did not give active power-down.");
   AST_LATENCY: assert property (
      st_q == dcap_pkg::DCAP_WAIT && cnt_q == 6'h1 && run_w && !col_w |-> hc_q == lat_q)
      else $error("First beat not at the programmed latency.");
   AST_ORDER: assert property (
      o_beat.valid |-> (il_q ? o_beat.col_fall[2:0] == (o_beat.col_rise[2:0] ^ 3'h1) :
         (o_beat.col_fall[1:0] == o_beat.col_rise[1:0] + 2'h1 &&
          o_beat.col_fall[2] == o_beat.col_rise[2])))
      else $error("Beat pair out of burst order.");
   AST_BURST_LEN: assert property (
      emit_w && last_w && !col_w |=> ##1 !o_beat.valid || $past(col_w) || !$past(run_w))
      else $error("Burst ran past its length.");
   AST_SREF: assert property (
      s_entry_sref |=> o_pwr_state == dcap_pkg::DCAP_SREF)
      else $error("Refresh with the gate falling did not give self-refresh.");
   AST_WAKE: assert property (
      s_wake |=> o_pwr_state == dcap_pkg::DCAP_RUN)
      else $error("High clock gate did not return to running.");
   AST_AP_CLOSE: assert property (
      close_w && !(act_w && pin_s_q.bank == bank_q) |=> !o_bank_open[$past(bank_q)])
      else $error("Autoprecharge left the bank open.");
endmodule
`default_nettype wire

//--- src/dcap_params.svh
/*
 Constants of the command and address front end: field positions,
 widths, reset values and latency codes. Assumes the includer wants
 plain macros only.
*/
`ifndef DCAP_PARAMS_SVH
`define DCAP_PARAMS_SVH
`define DCAP_ROW_W 13
`define DCAP_COL_W 10
`define DCAP_BANKS 8
`define DCAP_BANK_W 3
`define DCAP_LAT_W 6
`define DCAP_AP_BIT 10
`define DCAP_BC_BIT 12
`define DCAP_ADDLAT_ZERO 2'h0
`define DCAP_ADDLAT_LESS1 2'h1
`define DCAP_ADDLAT_LESS2 2'h2
`define DCAP_LAST_BL8 2'h3
`define DCAP_LAST_BL4 2'h1
`define DCAP_PINS_RST 20'hf0000
`define DCAP_CKE_RST 1'h0
`endif

//--- src/dcap_pkg.sv
/*
 Types of the command and address front end: the sampled pin group,
 the outgoing beat group and the one-hot state encodings.
 Assumes dcap_params.svh is on the include path.
*/
`include "dcap_params.svh"
`default_nettype none
package dcap_pkg;
   // Command pins as sampled on the rising clock edge.
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [`DCAP_BANK_W-1:0] bank;
      logic [`DCAP_ROW_W-1:0] addr;
   } dcap_pins_t;
   // One clock of burst output: two column beats, one per clock edge.
   typedef struct packed {
      logic valid;
      logic write;
      logic [`DCAP_BANK_W-1:0] bank;
      logic [`DCAP_ROW_W-1:0] row;
      logic [`DCAP_COL_W-1:0] col_rise;
      logic [`DCAP_COL_W-1:0] col_fall;
   } dcap_beat_t;
   typedef enum logic [2:0] {
      DCAP_IDLE = 3'h1,
      DCAP_WAIT = 3'h2,
      DCAP_BURST = 3'h4
   } dcap_burst_t;
   typedef enum logic [3:0] {
      DCAP_RUN = 4'h1,
      DCAP_PD_PRE = 4'h2,
      DCAP_PD_ACT = 4'h4,
      DCAP_SREF = 4'h8
   } dcap_pwr_t;
endpackage
`default_nettype wire

//--- sim/dcap_ctrl_model.sv
/*
 Controller-side model that drives the command pins and clock gate of
 the front end. Assumes the bench calls its tasks from one process.
*/
`default_nettype none
module dcap_ctrl_model (
   input wire logic i_clk,
   output dcap_pkg::dcap_pins_t o_pins,
   output logic o_cke
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pins start deselected and the clock gate low, as after power-up.
   initial begin
      o_pins = '{1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 13'h0};
      o_cke = 1'b0;
   end
   // One command for one clock, then deselect with inverted stale lines.
   // The bench orders activate before access and precharge before reopen.
   task automatic cmd(input logic cs_n, input logic [2:0] rcw, input logic [2:0] bk,
         input logic [12:0] a);
      @(posedge i_clk);
      o_pins <= '{cs_n, rcw[2], rcw[1], rcw[0], bk, a};
      @(posedge i_clk);
      o_pins <= '{1'b1, 1'b1, 1'b1, 1'b1, ~bk, ~a};
   endtask
   // Clock-gate level change; lowering it is only done with banks idle or for active power-down.
   task automatic gate(input logic v);
      @(posedge i_clk);
      o_cke <= v;
   endtask
   // Self-refresh entry: refresh code on the same edge as the gate drops, banks idle.
   task automatic sref_entry();
      @(posedge i_clk);
      o_pins <= '{1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 13'h0};
      o_cke <= 1'b0;
      @(posedge i_clk);
      o_pins <= '{1'b1, 1'b1, 1'b1, 1'b1, 3'h7, 13'h1fff};
   endtask
endmodule
`default_nettype wire

//--- sim/ddr3_command_address_port_tb.sv
/*
 Self-checking bench of the command and address front end.
 Assumes dcap_pkg and dcap_ctrl_model are compiled first.
*/
`default_nettype none
module ddr3_command_address_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, resetn, len8, otf, il, cke;
   logic [4:0] collat;
   logic [1:0] addlat;
   dcap_pkg::dcap_pins_t pins;
   logic [7:0] bank_open;
   logic [7:0][12:0] open_rows;
   dcap_pkg::dcap_beat_t beat, snap;
   dcap_pkg::dcap_pwr_t pwr;
   int failures, comparisons;

   dcap_cmd_port dut_u (.i_clk(clk), .i_resetn(resetn), .i_cke(cke), .i_pins(pins),
      .i_column_latency(collat), .i_additive_latency(addlat), .i_burst_len8(len8),
      .i_burst_otf(otf), .i_burst_interleave(il), .o_bank_open(bank_open),
      .o_open_rows(open_rows), .o_beat(beat), .o_pwr_state(pwr));
   dcap_ctrl_model ctrl_u (.i_clk(clk), .o_pins(pins), .o_cke(cke));

   // Free-running 50 ns clock.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   function automatic logic [9:0] exp_col(input logic [9:0] s, input logic [2:0] k,
         input logic ilv);
      return ilv ? {s[9:3], s[2:0] ^ k} : {s[9:3], s[2] ^ k[2], 2'(s[1:0] + k[1:0])};
   endfunction

   // Column command, then latency and every beat pair checked against the ordering rules.
   task automatic burst(input logic wr, input logic [1:0] alc, input logic ilv,
         input logic bl8, input logic [2:0] bk, input logic [12:0] a, input logic [12:0] row);
      int lat;
      int n;
      lat = (alc == 2'h1) ? 9 : (alc == 2'h2) ? 8 : 5;
      @(posedge clk);
      addlat <= alc;
      il <= ilv;
      len8 <= bl8 ^ otf;
      ctrl_u.cmd(1'b0, {2'b10, ~wr}, bk, a);
      n = 0;
      do begin
         tick(1);
         n++;
      end while (beat.valid !== 1'b1 && n < 40);
      chk("latency", 64'(lat + 2), 64'(n));
      chk("target", {46'h0, wr, bk, row, 1'b1}, 64'({beat.write, beat.bank, beat.row,
         beat.valid}));
      for (int k = 0; k < (bl8 ? 8 : 4); k += 2) begin
         chk("col_rise", 64'(exp_col(a[9:0], 3'(k), ilv)), 64'(beat.col_rise));
         chk("col_fall", 64'(exp_col(a[9:0], 3'(k + 1), ilv)), 64'(beat.col_fall));
         tick(1);
      end
      chk("burst end", 64'h0, 64'(beat.valid));
   endtask

   task automatic finish_test;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Hang guard: the tests need under two hundred clocks.
   initial begin
      repeat (4000) @(posedge clk);
      failures++;
      finish_test();
   end

   // Main sequence of tests.
   initial begin
      resetn = 1'b0;
      collat = 5'h05;
      addlat = 2'h0;
      len8 = 1'b1;
      otf = 1'b0;
      il = 1'b0;
      failures = 0;
      comparisons = 0;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      ctrl_u.gate(1'b1);
      tick(4);
      chk("reset state", 64'h1, 64'({bank_open, beat, pwr}));
      $display("test reset done");
      ctrl_u.cmd(1'b0, 3'b011, 3'h3, 13'h1abc);
      ctrl_u.cmd(1'b0, 3'b011, 3'h5, 13'h0123);
      ctrl_u.cmd(1'b1, 3'b011, 3'h0, 13'h0fff);
      tick(4);
      chk("bank_open", 64'h28, 64'(bank_open));
      chk("row3", 64'h1abc, 64'(open_rows[3]));
      chk("row5", 64'h0123, 64'(open_rows[5]));
      $display("test activate done");
      burst(1'b0, 2'h0, 1'b0, 1'b1, 3'h3, 13'h1001, 13'h1abc);
      burst(1'b1, 2'h1, 1'b1, 1'b1, 3'h5, 13'h12cd, 13'h0123);
      @(posedge clk);
      otf <= 1'b1;
      burst(1'b0, 2'h2, 1'b0, 1'b0, 3'h3, 13'h0007, 13'h1abc);
      burst(1'b1, 2'h0, 1'b1, 1'b0, 3'h5, 13'h0406, 13'h0123);
      tick(2);
      chk("autoprecharge", 64'h08, 64'(bank_open));
      @(posedge clk);
      otf <= 1'b0;
      $display("test bursts done");
      ctrl_u.cmd(1'b0, 3'b011, 3'h5, 13'h0555);
      ctrl_u.cmd(1'b0, 3'b010, 3'h3, 13'h0000);
      tick(4);
      chk("precharge one", 64'h20, 64'(bank_open));
      ctrl_u.cmd(1'b0, 3'b010, 3'h0, 13'h0400);
      ctrl_u.cmd(1'b0, 3'b001, 3'h0, 13'h0000);
      tick(4);
      chk("precharge all", 64'h00, 64'(bank_open));
      $display("test precharge done");
      ctrl_u.gate(1'b0);
      tick(5);
      chk("pd precharged", 64'h2, 64'(pwr));
      ctrl_u.gate(1'b1);
      tick(5);
      chk("wake", 64'h1, 64'(pwr));
      ctrl_u.sref_entry();
      tick(5);
      chk("self refresh", 64'h8, 64'(pwr));
      ctrl_u.gate(1'b1);
      tick(5);
      chk("sref wake", 64'h1, 64'(pwr));
      ctrl_u.cmd(1'b0, 3'b011, 3'h1, 13'h0011);
      tick(2);
      @(posedge clk);
      addlat <= 2'h2;
      ctrl_u.cmd(1'b0, 3'b101, 3'h1, 13'h1000);
      tick(6);
      ctrl_u.gate(1'b0);
      tick(6);
      chk("pd active", 64'h4, 64'(pwr));
      snap = beat;
      chk("frozen valid", 64'h1, 64'(snap.valid));
      tick(5);
      chk("frozen beat", 64'(snap), 64'(beat));
      ctrl_u.gate(1'b1);
      tick(5);
      chk("wake", 64'h1, 64'(pwr));
      $display("test power done");
      finish_test();
   end
endmodule
`default_nettype wire
